// ---- src/rsu_top.sv ----
`timescale 1ns/1ps
module rsu_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic rst_pin_n_in,
    input wire logic system_clock_mon_in,
    input wire logic cmp_above_in,
    input wire logic supply_monitor_enable_in,
    input wire logic supply_high_level_in,
    input wire logic supply_ok_in,
    input wire logic wdt_overflow_in,
    input wire logic wdt_disable_in,
    input wire rsu_pkg::rsu_flash_req_t flash_req_in,
    input wire rsu_pkg::rsu_sfr_req_t sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    output logic sys_rst_out,
    output logic wdt_enable_out,
    output logic wdt_tick_out
);
    import rsu_pkg::*;

    // ==========================================
    // synchronised inputs
    logic pin_s, cmp_s, supply_s, system_clock_s, clk_loss;

    rsu_sync3 #(.RST_VAL(1'b1)) u_pin_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(rst_pin_n_in),
        .sync_out(pin_s)
    );

    rsu_sync3 #(.RST_VAL(1'b1)) u_cmp_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(cmp_above_in),
        .sync_out(cmp_s)
    );

    rsu_sync3 #(.RST_VAL(1'b1)) u_supply_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(supply_ok_in),
        .sync_out(supply_s)
    );

    rsu_sync3 #(.RST_VAL(1'b0)) u_system_clock_sync (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .async_in(system_clock_mon_in),
        .sync_out(system_clock_s)
    );

    // ==========================================
    // state
    rsu_state_t state_q, state_d;
    logic [HOLD_W-1:0] hold_q, hold_d;
    logic [6:0] cause_q, cause_d;
    logic [6:0] flags_q, flags_d;
    logic mcd_en_q, mcd_en_d;
    logic cmp_en_q, cmp_en_d;
    logic vdm_en_q, vdm_en_d;
    logic wdt_en_q, wdt_en_d;
    logic [WDT_W-1:0] wdt_div_q, wdt_div_d;
    logic wdt_tick_q, wdt_tick_d;
    logic sys_rst_q, sys_rst_d;
    logic [7:0] rdata_q, rdata_d;

    rsu_clk_loss u_clk_loss (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .clk_lvl_in(system_clock_s),
        .enable_in(mcd_en_q),
        .lost_out(clk_loss)
    );

    // ==========================================
    // reset sources
    logic reg_hit, reg_wr, flash_wr, flash_rd, vdm_ok, rsvd_hit;
    logic [6:0] src;
    logic level_any;

    assign reg_hit = (sfr_req_in.addr == RSU_REG_ADDR);
    // the core is held during reset, so writes count only while running
    assign reg_wr = sfr_req_in.wr && reg_hit && (state_q == ST_RUN);
    assign flash_wr = flash_req_in.wr && flash_req_in.wr_en;
    assign flash_rd = flash_req_in.code_rd;
    assign vdm_ok = supply_high_level_in && supply_monitor_enable_in && vdm_en_q;
    assign rsvd_hit = (flash_wr || flash_rd || flash_req_in.fetch)
        && (flash_req_in.addr >= FLASH_RSVD_BASE);

    // one request line per cause, each in its flag position
    always_comb begin
        src = '0;
        src[BIT_POR] = supply_monitor_enable_in && vdm_en_q && !supply_s;
        src[BIT_PIN] = !pin_s;
        src[BIT_CLK] = clk_loss;
        src[BIT_CMP] = cmp_en_q && !cmp_s;
        src[BIT_WDT] = wdt_en_q && wdt_overflow_in;
        src[BIT_FLASH] = rsvd_hit || flash_req_in.sec_deny
            || ((flash_wr || flash_rd) && !vdm_ok);
        src[BIT_SOFT] = reg_wr && sfr_req_in.wdata[BIT_SOFT];
    end

    // level causes keep the reset stretched for as long as they last
    assign level_any = src[BIT_POR] || src[BIT_PIN] || src[BIT_CLK] || src[BIT_CMP];

    // fixed priority when several causes coincide, one flag only
    function automatic logic [6:0] pick_cause(input logic [6:0] s);
        logic [6:0] c;
        c = '0;
        if (s[BIT_POR]) begin
            // power-on wins, so the other flags simply read zero then
            c[BIT_POR] = 1'b1;
        end else if (s[BIT_PIN]) begin
            c[BIT_PIN] = 1'b1;
        end else if (s[BIT_CLK]) begin
            c[BIT_CLK] = 1'b1;
        end else if (s[BIT_CMP]) begin
            c[BIT_CMP] = 1'b1;
        end else if (s[BIT_WDT]) begin
            c[BIT_WDT] = 1'b1;
        end else if (s[BIT_FLASH]) begin
            c[BIT_FLASH] = 1'b1;
        end else begin
            c[BIT_SOFT] = s[BIT_SOFT];
        end
        return c;
    endfunction

    // ==========================================
    // reset sequencer and register file next state
    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        cause_d = cause_q;
        flags_d = flags_q;
        mcd_en_d = mcd_en_q;
        cmp_en_d = cmp_en_q;
        vdm_en_d = vdm_en_q;
        wdt_en_d = wdt_en_q;
        unique case (state_q)
            ST_RUN: begin
                if (|src) begin
                    state_d = ST_HOLD;
                    hold_d = HOLD_W'(HOLD_CYC - 1);
                    cause_d = pick_cause(src);
                end else if (reg_wr) begin
                    // read side shows flags, so enables are write-only
                    mcd_en_d = sfr_req_in.wdata[BIT_CLK];
                    cmp_en_d = sfr_req_in.wdata[BIT_CMP];
                    vdm_en_d = sfr_req_in.wdata[BIT_POR];
                end
                if (wdt_disable_in) begin
                    wdt_en_d = 1'b0;
                end
            end
            ST_HOLD: begin
                if (level_any) begin
                    hold_d = HOLD_W'(HOLD_CYC - 1);
                end else if (hold_q == '0) begin
                    state_d = ST_EXIT;
                end else begin
                    hold_d = hold_q - HOLD_W'(1);
                end
            end
            ST_EXIT: begin
                if (|src) begin
                    // a cause arriving on the way out starts a fresh reset
                    state_d = ST_HOLD;
                    hold_d = HOLD_W'(HOLD_CYC - 1);
                    cause_d = pick_cause(src);
                end else begin
                    state_d = ST_RUN;
                    flags_d = cause_q;
                    mcd_en_d = 1'b0;
                    cmp_en_d = 1'b0;
                    wdt_en_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_HOLD;
                hold_d = HOLD_W'(HOLD_CYC - 1);
            end
        endcase
        // only the system reset line leaves here; the pin is input only
        sys_rst_d = (state_d != ST_RUN);
    end

    // ==========================================
    // watchdog prescaler and register read
    always_comb begin
        wdt_div_d = '0;
        wdt_tick_d = 1'b0;
        if (!sys_rst_q) begin
            if (wdt_div_q == WDT_W'(WDT_DIV - 1)) begin
                wdt_tick_d = 1'b1;
            end else begin
                wdt_div_d = wdt_div_q + WDT_W'(1);
            end
        end
        rdata_d = '0;
        if (sfr_req_in.rd && reg_hit) begin
            rdata_d = {1'b0, flags_q};
        end
    end

    // registers only
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_HOLD;
            hold_q <= HOLD_W'(HOLD_CYC - 1);
            cause_q <= CAUSE_RST;
            flags_q <= FLAGS_RST;
            mcd_en_q <= 1'b0;
            cmp_en_q <= 1'b0;
            vdm_en_q <= 1'b0;
            wdt_en_q <= 1'b1;
            wdt_div_q <= '0;
            wdt_tick_q <= 1'b0;
            sys_rst_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            cause_q <= cause_d;
            flags_q <= flags_d;
            mcd_en_q <= mcd_en_d;
            cmp_en_q <= cmp_en_d;
            vdm_en_q <= vdm_en_d;
            wdt_en_q <= wdt_en_d;
            wdt_div_q <= wdt_div_d;
            wdt_tick_q <= wdt_tick_d;
            sys_rst_q <= sys_rst_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_out = rdata_q;
    assign sys_rst_out = sys_rst_q;
    assign wdt_enable_out = wdt_en_q;
    assign wdt_tick_out = wdt_tick_q;

    // ==========================================
    // checks
    chk_pin_holds_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        !pin_s |=> sys_rst_q) else $error("pin low did not hold reset");

    chk_clk_loss_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        clk_loss |=> sys_rst_q) else $error("clock loss did not reset");

    chk_exit_flags: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_q == ST_EXIT && src == '0) |=> (flags_q == $past(cause_q)) && !sys_rst_q)
        else $error("flags not loaded from cause at exit");

    chk_clk_en_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (reg_wr && src == '0) |=> mcd_en_q == $past(sfr_req_in.wdata[BIT_CLK]))
        else $error("clock loss enable not written");

    chk_cmp_en_write: assert property (@(posedge mclk_in) disable iff (rst_in)
        (reg_wr && src == '0) |=> cmp_en_q == $past(sfr_req_in.wdata[BIT_CMP]))
        else $error("comparator enable not written");

    chk_cmp_holds: assert property (@(posedge mclk_in) disable iff (rst_in)
        (cmp_en_q && !cmp_s) |=> sys_rst_q) else $error("comparator did not hold reset");

    chk_wdt_after_rst: assert property (@(posedge mclk_in) disable iff (rst_in)
        $fell(sys_rst_q) |-> wdt_en_q ##12 (wdt_tick_q || sys_rst_q))
        else $error("watchdog not enabled or divider wrong");

    chk_wdt_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        (wdt_en_q && wdt_overflow_in) |=> sys_rst_q) else $error("watchdog overflow ignored");

    chk_flash_fault: assert property (@(posedge mclk_in) disable iff (rst_in)
        src[BIT_FLASH] |=> sys_rst_q) else $error("flash fault did not reset");

    chk_soft_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        (reg_wr && sfr_req_in.wdata[BIT_SOFT]) |=> sys_rst_q ##[1:40] (!sys_rst_q || level_any))
        else $error("soft reset missing or stuck");

    chk_monitor_reset: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!supply_s && !(supply_monitor_enable_in && vdm_en_q)
        && {src[BIT_FLASH:BIT_CLK], src[BIT_PIN]} == '0 && !sys_rst_q)
        |=> !sys_rst_q) else $error("unselected monitor caused reset");

    chk_flag_onehot: assert property (@(posedge mclk_in) disable iff (rst_in)
        !sys_rst_q |-> $onehot(flags_q)) else $error("flags not one-hot");

    chk_hold_min: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(sys_rst_q) |-> sys_rst_q [*8]) else $error("reset pulse too short");
endmodule // rsu_top

// ---- src/rsu_pkg.sv ----
// ==========================================
// reset source unit shared constants
package rsu_pkg;

    // ==========================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    // least time a pulsed cause keeps the system in reset
    localparam int HOLD_NS = 100;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 4;
    // monitored clock stuck at one level longer than this is a loss
    localparam int MCD_TIMEOUT_NS = 500;
    localparam int MCD_CYC = (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MCD_W = 8;
    // watchdog runs on the system clock divided by this
    localparam int WDT_DIV = 12;
    localparam int WDT_W = 4;

    // ==========================================
    // register map
    localparam logic [7:0] RSU_REG_ADDR = 8'hEF;
    localparam int BIT_PIN = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_CLK = 2;
    localparam int BIT_WDT = 3;
    localparam int BIT_SOFT = 4;
    localparam int BIT_CMP = 5;
    localparam int BIT_FLASH = 6;
    localparam logic [6:0] FLAGS_RST = 7'h02;
    localparam logic [6:0] CAUSE_RST = 7'h02;
    // first flash address of the reserved space
    localparam logic [15:0] FLASH_RSVD_BASE = 16'hFC00;

    // ==========================================
    // types
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_EXIT = 2'b11
    } rsu_state_t;

    typedef struct packed {
        logic wr;
        logic wr_en;
        logic code_rd;
        logic fetch;
        logic sec_deny;
        logic [15:0] addr;
    } rsu_flash_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rsu_sfr_req_t;

endpackage

// ---- src/rsu_sync3.sv ----
`timescale 1ns/1ps
// ==========================================
// three-stage synchroniser, output moves when stages two and three agree
module rsu_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    // agreement filter, stage one is never looked at here
    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule // rsu_sync3

// ---- src/rsu_clk_loss.sv ----
`timescale 1ns/1ps
// ==========================================
// one-shot watching the synchronised system clock level
module rsu_clk_loss (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic clk_lvl_in,
    input wire logic enable_in,
    output logic lost_out
);
    import rsu_pkg::*;

    logic [MCD_W-1:0] cnt_q, cnt_d;
    logic prev_q, lost_q, lost_d;

    // every level change retriggers; count saturates at the timeout
    always_comb begin
        cnt_d = cnt_q;
        if (!enable_in || (clk_lvl_in != prev_q)) begin
            cnt_d = '0;
        end else if (cnt_q != MCD_W'(MCD_CYC)) begin
            cnt_d = cnt_q + MCD_W'(1);
        end
        lost_d = enable_in && (cnt_d == MCD_W'(MCD_CYC));
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            prev_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            prev_q <= clk_lvl_in;
            lost_q <= lost_d;
        end
    end

    assign lost_out = lost_q;
endmodule // rsu_clk_loss

// ---- verif/rsu_far_model.sv ----
`timescale 1ns/1ps
// ==========================================
// far side: reset pin circuit, monitored clock, comparator, supply monitor
module rsu_far_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic pin_low_in,
    input wire logic clk_stop_in,
    input wire logic cmp_low_in,
    input wire logic supply_low_in,
    output logic rst_pin_n_out,
    output logic system_clock_mon_out,
    output logic cmp_above_out,
    output logic supply_ok_out
);
    // pulled-up pin, so a released pin reads high
    assign rst_pin_n_out = ~pin_low_in;
    // comparator is settled high before it is selected, no turn-on chatter
    assign cmp_above_out = ~cmp_low_in;
    // supply stays stable above threshold unless a droop is asked for
    assign supply_ok_out = ~supply_low_in;
    logic [1:0] div_q;
    // monitored clock at one eighth rate; the agreement filter needs each level to last two clocks
    // a stop freezes it at its last level
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 2'h0;
            system_clock_mon_out <= 1'b0;
        end else if (!clk_stop_in) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                system_clock_mon_out <= ~system_clock_mon_out;
            end
        end
    end
endmodule // rsu_far_model

// ---- verif/test_reset_source_unit.sv ----
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the reset source unit
module test_reset_source_unit;
    import rsu_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic pin_low = 1'b0;
    logic clk_stop = 1'b0;
    logic cmp_low = 1'b0;
    logic sup_low = 1'b0;
    logic mon_en = 1'b0;
    logic mon_hi = 1'b0;
    logic wdt_ovf = 1'b0;
    logic wdt_dis = 1'b0;
    rsu_flash_req_t flash_req = '0;
    rsu_sfr_req_t sfr_req = '0;
    logic rst_pin_n, system_clock_mon, cmp_above, supply_ok;
    logic [7:0] rdata;
    logic sys_rst, wdt_en, wdt_tick;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    // ==========================================
    // clock, far side and device
    always #(CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;

    rsu_far_model far_u (.mclk_in(mclk_in), .rst_in(rst_in), .pin_low_in(pin_low), .clk_stop_in(clk_stop),
        .cmp_low_in(cmp_low), .supply_low_in(sup_low), .rst_pin_n_out(rst_pin_n), .system_clock_mon_out(system_clock_mon),
        .cmp_above_out(cmp_above), .supply_ok_out(supply_ok));

    rsu_top dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .rst_pin_n_in(rst_pin_n), .system_clock_mon_in(system_clock_mon),
        .cmp_above_in(cmp_above), .supply_monitor_enable_in(mon_en), .supply_high_level_in(mon_hi),
        .supply_ok_in(supply_ok), .wdt_overflow_in(wdt_ovf), .wdt_disable_in(wdt_dis),
        .flash_req_in(flash_req), .sfr_req_in(sfr_req), .sfr_rdata_out(rdata), .sys_rst_out(sys_rst),
        .wdt_enable_out(wdt_en), .wdt_tick_out(wdt_tick));

    // ==========================================
    // shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // bounded wait, a hung reset shows up as a mismatch not a hang
    task automatic wait_lvl(input logic v, input int max);
        int i;
        for (i = 0; i < max; i++) begin
            if (sys_rst === v) begin
                break;
            end
            @(posedge mclk_in);
            #1;
        end
        check(sys_rst, v);
    endtask

    // plain whole-byte writes only, flags never read back as enables
    task automatic wr(input logic [7:0] d);
        @(posedge mclk_in);
        sfr_req <= '{addr: RSU_REG_ADDR, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge mclk_in);
        sfr_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] exp);
        @(posedge mclk_in);
        sfr_req <= '{addr: RSU_REG_ADDR, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge mclk_in);
        sfr_req <= '0;
        #1;
        check(rdata, exp);
    endtask

    task automatic end_cause(input logic [7:0] flags);
        wait_lvl(1'b0, 200);
        rd_chk(flags);
    endtask

    task automatic send_flash(input rsu_flash_req_t r);
        @(posedge mclk_in);
        flash_req <= r;
        @(posedge mclk_in);
        flash_req <= '0;
    endtask

    // ==========================================
    // scenarios
    task automatic t_power;
        int n;
        end_cause(8'h02);
        check(wdt_en, 1'b1);
        n = 0;
        while (wdt_tick !== 1'b1 && n < 20) begin
            cyc_n(1);
            n++;
        end
        n = 0;
        do begin
            cyc_n(1);
            n++;
        end while (wdt_tick !== 1'b1 && n < 20);
        check(8'(n), 8'(WDT_DIV));
        $display("test power done");
    endtask

    task automatic t_soft_wdt;
        wr(8'h10);
        cyc_n(1);
        check(sys_rst, 1'b1);
        end_cause(8'h10);
        @(posedge mclk_in);
        wdt_ovf <= 1'b1;
        @(posedge mclk_in);
        wdt_ovf <= 1'b0;
        cyc_n(1);
        check(sys_rst, 1'b1);
        end_cause(8'h08);
        check(wdt_en, 1'b1);
        @(posedge mclk_in);
        wdt_dis <= 1'b1;
        @(posedge mclk_in);
        wdt_dis <= 1'b0;
        wdt_ovf <= 1'b1;
        @(posedge mclk_in);
        wdt_ovf <= 1'b0;
        cyc_n(5);
        check(sys_rst, 1'b0);
        $display("test soft and watchdog done");
    endtask

    task automatic t_pin;
        @(posedge mclk_in);
        pin_low <= 1'b1;
        wait_lvl(1'b1, 10);
        cyc_n(30);
        check(sys_rst, 1'b1);
        pin_low <= 1'b0;
        end_cause(8'h01);
        check(wdt_en, 1'b1);
        $display("test pin done");
    endtask

    // enable then disable, stopped clock must be ignored; enabled again, a stopped clock must reset
    task automatic t_clk;
        wr(8'h04);
        wr(8'h00);
        clk_stop <= 1'b1;
        cyc_n(80);
        check(sys_rst, 1'b0);
        clk_stop <= 1'b0;
        wr(8'h04);
        cyc_n(80);
        check(sys_rst, 1'b0);
        clk_stop <= 1'b1;
        wait_lvl(1'b1, 80);
        clk_stop <= 1'b0;
        end_cause(8'h04);
        $display("test clock loss done");
    endtask

    task automatic t_cmp;
        wr(8'h20);
        cyc_n(5);
        check(sys_rst, 1'b0);
        cmp_low <= 1'b1;
        wait_lvl(1'b1, 10);
        cyc_n(30);
        check(sys_rst, 1'b1);
        cmp_low <= 1'b0;
        end_cause(8'h20);
        cmp_low <= 1'b1;
        cyc_n(20);
        check(sys_rst, 1'b0);
        cmp_low <= 1'b0;
        $display("test comparator done");
    endtask

    // fields: wr, wr_en, code_rd, fetch, sec_deny, addr
    task automatic t_flash_supply;
        rsu_flash_req_t bad [5] = '{{5'b00010, 16'hFC00}, {5'b00100, 16'hFFFF}, {5'b11000, 16'hFC00},
            {5'b00001, 16'h0000}, {5'b00100, 16'h0100}};
        rsu_flash_req_t good [2] = '{{5'b00010, 16'hFBFF}, {5'b10000, 16'hFC00}};
        foreach (bad[i]) begin
            send_flash(bad[i]);
            cyc_n(1);
            check(sys_rst, 1'b1);
            end_cause(8'h40);
        end
        foreach (good[i]) begin
            send_flash(good[i]);
            cyc_n(3);
            check(sys_rst, 1'b0);
        end
        mon_en <= 1'b1;
        mon_hi <= 1'b1;
        sup_low <= 1'b1;
        cyc_n(20);
        check(sys_rst, 1'b0);
        sup_low <= 1'b0;
        cyc_n(10);
        wr(8'h02);
        send_flash({5'b00100, 16'h0100});
        cyc_n(3);
        check(sys_rst, 1'b0);
        sup_low <= 1'b1;
        wait_lvl(1'b1, 10);
        sup_low <= 1'b0;
        end_cause(8'h02);
        // monitor on and selected, but low threshold: flash access is a fault
        mon_hi <= 1'b0;
        send_flash({5'b00100, 16'h0100});
        cyc_n(1);
        check(sys_rst, 1'b1);
        end_cause(8'h40);
        $display("test flash and supply done");
    endtask

    // ==========================================
    // run ceiling and main sequence
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_power();
        t_soft_wdt();
        t_pin();
        t_clk();
        t_cmp();
        t_flash_supply();
        stop_test();
    end
endmodule // test_reset_source_unit
